// [hdl/dpc_deser_cfg.sv]
// Deserializer pin configuration, lock handling, self-test and register file
//
// Overview of operation
// - Locked: output enable alone controls outputs
// - Unlocked: state choice and enable control outputs
// - Power-down low: outputs off except input boost, registers reset
// - Swing choice high selects larger swing
// - Low band choice selects spread frequency band
// - No spreading above the output clock limit
// - Bit order choice puts MSB on lane four
// - Modes 00/01: native, filter off/on
// - Modes 10/11: two legacy serializer families
// - Three-bit input selects spread range
// - Boost strap high enables input equalization
// - Self-test request high enters self-test
// - Pass high until an error is seen
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dpc_deser_cfg
    import dpc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    // Pins
    input wire logic power_down_bar,
    input wire logic output_drive_allow,
    input wire logic unlocked_output_state_choice,
    input wire logic lvds_swing_choice,
    input wire logic low_band_choice,
    input wire logic bit_order_choice,
    input wire logic [1:0] op_mode,
    input wire logic [2:0] spread_range_select,
    input wire logic self_test_request,
    // Shared strap / pass pin
    input wire logic pass_pin_in,
    output logic pass_pin_out,
    output logic pass_pin_oe,
    // From the receive core
    input wire logic pll_locked,
    input wire logic bit_error,
    input wire logic [7:0] out_clk_mhz,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Configuration outputs
    output logic lock_out,
    output logic out_drive_en,
    output logic out_hold_state,
    output logic lvds_swing_high,
    output logic spread_low_band,
    output logic spread_en,
    output logic [2:0] spread_range,
    output logic msb_on_lane_four,
    output logic native_mode,
    output logic filter_en,
    output logic legacy_mode_a,
    output logic legacy_mode_b,
    output logic input_boost_en,
    output logic self_test_active,
    output logic irq
);
    typedef struct packed {
        logic strap_taken;
        logic boost;
        logic [2:0] ctrl_val;
        logic [2:0] ctrl_ovr;
        logic spread_on;
        logic [DPC_EV_W-1:0] int_stat;
        logic [DPC_EV_W-1:0] int_mask;
        logic lock_prev;
        logic over_prev;
        logic [31:0] rdata;
        logic lock_out;
        logic drive_en;
        logic hold_state;
        logic swing_high;
        logic low_band;
        logic spread_en;
        logic [2:0] spread_range;
        logic msb_lane4;
        logic native;
        logic filter;
        logic legacy_a;
        logic legacy_b;
        logic pass_out;
        logic pass_oe;
        logic irq;
    } dpc_state_s;

    dpc_state_s st_r;
    dpc_state_s st_nxt;

    // Tracker holds its own state; power down reaches it through the request
    dpc_test_if tif ();

    dpc_self_test u_self_test (
        .core_clk (core_clk),
        .arst_n (arst_n),
        .tif (tif)
    );

    // Self-test only runs while powered up
    assign tif.request = power_down_bar & self_test_request;
    assign tif.error_pulse = bit_error;

    // Offsets cut to bus width once, so every compare is the same size
    logic [ADDR_W-1:0] ofs_ctrl;
    logic [ADDR_W-1:0] ofs_status;
    logic [ADDR_W-1:0] ofs_int_stat;
    logic [ADDR_W-1:0] ofs_int_mask;
    logic [ADDR_W-1:0] ofs_id;

    assign ofs_ctrl = ADDR_W'(DPC_OFS_CTRL);
    assign ofs_status = ADDR_W'(DPC_OFS_STATUS);
    assign ofs_int_stat = ADDR_W'(DPC_OFS_INT_STAT);
    assign ofs_int_mask = ADDR_W'(DPC_OFS_INT_MASK);
    assign ofs_id = ADDR_W'(DPC_OFS_ID);

    // Strobe decodes shared by the write and read-clear paths
    logic wr_ctrl;
    logic wr_mask;
    logic rd_stat;

    assign wr_ctrl = reg_wr & (reg_addr == ofs_ctrl);
    assign wr_mask = reg_wr & (reg_addr == ofs_int_mask);
    assign rd_stat = reg_rd & (reg_addr == ofs_int_stat);

    logic [2:0] pin_vals;
    logic [2:0] eff_vals;
    logic over_limit;
    logic [DPC_EV_W-1:0] ev_set;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [31:0] rd_value;

    assign pin_vals = {bit_order_choice, low_band_choice, lvds_swing_choice};
    assign over_limit = (out_clk_mhz > DPC_SPREAD_MAX_MHZ);

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[DPC_CTRL_ORDER_BIT:DPC_CTRL_SWING_BIT] = st_r.ctrl_val;
        ctrl_word[DPC_CTRL_OVR_LSB +: 3] = st_r.ctrl_ovr;
        ctrl_word[DPC_CTRL_SPREAD_ON_BIT] = st_r.spread_on;
    end

    // Status is live, except the pass bit, where a failure sticks until the test is left
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[DPC_ST_LOCK_BIT] = st_r.lock_out;
        status_word[DPC_ST_TEST_BIT] = tif.active;
        status_word[DPC_ST_PASS_BIT] = tif.pass;
        status_word[DPC_ST_BOOST_BIT] = st_r.boost;
        status_word[DPC_ST_SPREAD_BIT] = st_r.spread_en;
        status_word[DPC_ST_MODE_LSB +: 2] = op_mode;
    end

    always_comb begin
        rd_value = 32'h0000_0000;
        if (reg_addr == ofs_ctrl) begin
            rd_value = ctrl_word;
        end else if (reg_addr == ofs_status) begin
            rd_value = status_word;
        end else if (reg_addr == ofs_int_stat) begin
            rd_value = {{(32 - DPC_EV_W){1'b0}}, st_r.int_stat};
        end else if (reg_addr == ofs_int_mask) begin
            rd_value = {{(32 - DPC_EV_W){1'b0}}, st_r.int_mask};
        end else if (reg_addr == ofs_id) begin
            rd_value = DPC_ID_VALUE;
        end
    end

    always_comb begin
        ev_set = '0;
        ev_set[DPC_EV_LOCK_GAINED] = pll_locked & ~st_r.lock_prev;
        ev_set[DPC_EV_LOCK_LOST] = ~pll_locked & st_r.lock_prev;
        ev_set[DPC_EV_TEST_ERROR] = tif.error_event;
        ev_set[DPC_EV_SPREAD_BLOCKED] = st_r.spread_on & over_limit & ~st_r.over_prev;
    end

    // Each setting comes from its pin unless software took it over
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_eff
            assign eff_vals[gi] = st_r.ctrl_ovr[gi] ? st_r.ctrl_val[gi] : pin_vals[gi];
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.lock_prev = pll_locked;
        st_nxt.over_prev = over_limit;
        // Read data stand for one cycle only
        st_nxt.rdata = reg_rd ? rd_value : 32'h0000_0000;

        if (!power_down_bar) begin
            // Register file back to reset, every pin released
            // Boost keeps its strap value through power down
            st_nxt.strap_taken = 1'b0;
            st_nxt.ctrl_val = DPC_CTRL_VAL_RST;
            st_nxt.ctrl_ovr = DPC_CTRL_OVR_RST;
            st_nxt.spread_on = DPC_CTRL_SPREAD_ON_RST;
            st_nxt.int_stat = DPC_INT_STAT_RST;
            st_nxt.int_mask = DPC_INT_MASK_RST;
            st_nxt.lock_out = 1'b0;
            st_nxt.drive_en = 1'b0;
            st_nxt.hold_state = 1'b0;
            st_nxt.swing_high = 1'b0;
            st_nxt.low_band = 1'b0;
            st_nxt.spread_en = 1'b0;
            st_nxt.spread_range = 3'h0;
            st_nxt.msb_lane4 = 1'b0;
            st_nxt.native = 1'b0;
            st_nxt.filter = 1'b0;
            st_nxt.legacy_a = 1'b0;
            st_nxt.legacy_b = 1'b0;
            st_nxt.pass_out = 1'b0;
            st_nxt.pass_oe = 1'b0;
            st_nxt.irq = 1'b0;
        end else begin
            // Strap is read before the shared pin turns into an output
            if (!st_r.strap_taken) begin
                st_nxt.boost = pass_pin_in;
                st_nxt.strap_taken = 1'b1;
            end

            if (wr_ctrl) begin
                st_nxt.ctrl_val = reg_wdata[DPC_CTRL_ORDER_BIT:DPC_CTRL_SWING_BIT];
                st_nxt.ctrl_ovr = reg_wdata[DPC_CTRL_OVR_LSB +: 3];
                st_nxt.spread_on = reg_wdata[DPC_CTRL_SPREAD_ON_BIT];
            end
            if (wr_mask) begin
                st_nxt.int_mask = reg_wdata[DPC_EV_W-1:0];
            end

            // A new event beats a read-clear in the same cycle
            if (rd_stat) begin
                st_nxt.int_stat = ev_set;
            end else begin
                st_nxt.int_stat = st_r.int_stat | ev_set;
            end

            st_nxt.lock_out = pll_locked;
            if (pll_locked) begin
                st_nxt.drive_en = output_drive_allow;
                st_nxt.hold_state = 1'b0;
            end else begin
                st_nxt.drive_en = output_drive_allow & unlocked_output_state_choice;
                st_nxt.hold_state = 1'b1;
            end

            st_nxt.swing_high = eff_vals[DPC_CTRL_SWING_BIT];
            st_nxt.low_band = eff_vals[DPC_CTRL_LOWBAND_BIT];
            st_nxt.msb_lane4 = eff_vals[DPC_CTRL_ORDER_BIT];
            // Blocked above the limit even if software asks for it
            st_nxt.spread_en = st_r.spread_on & ~over_limit;
            st_nxt.spread_range = spread_range_select;

            st_nxt.native = (op_mode == DPC_MODE_NATIVE_RAW) || (op_mode == DPC_MODE_NATIVE_FILT);
            st_nxt.filter = (op_mode == DPC_MODE_NATIVE_FILT);
            st_nxt.legacy_a = (op_mode == DPC_MODE_LEGACY_A);
            st_nxt.legacy_b = (op_mode == DPC_MODE_LEGACY_B);

            // Outside self-test the pin just shows a steady pass
            st_nxt.pass_oe = st_r.strap_taken;
            st_nxt.pass_out = tif.active ? tif.pass : 1'b1;

            st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);
        end
    end

    // Async reset clears all; power down is the synchronous second reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign lock_out = st_r.lock_out;
    assign out_drive_en = st_r.drive_en;
    assign out_hold_state = st_r.hold_state;
    assign lvds_swing_high = st_r.swing_high;
    assign spread_low_band = st_r.low_band;
    assign spread_en = st_r.spread_en;
    assign spread_range = st_r.spread_range;
    assign msb_on_lane_four = st_r.msb_lane4;
    assign native_mode = st_r.native;
    assign filter_en = st_r.filter;
    assign legacy_mode_a = st_r.legacy_a;
    assign legacy_mode_b = st_r.legacy_b;
    assign input_boost_en = st_r.boost;
    assign self_test_active = tif.active;
    assign pass_pin_out = st_r.pass_out;
    assign pass_pin_oe = st_r.pass_oe;
    assign irq = st_r.irq;
endmodule : dpc_deser_cfg
`default_nettype wire

// [hdl/dpc_pkg.sv]
// Shared constants and types for the deserializer pin configuration block
`default_nettype none
package dpc_pkg;
    // Register byte offsets
    localparam logic [7:0] DPC_OFS_CTRL = 8'h00;
    localparam logic [7:0] DPC_OFS_STATUS = 8'h04;
    localparam logic [7:0] DPC_OFS_INT_STAT = 8'h08;
    localparam logic [7:0] DPC_OFS_INT_MASK = 8'h0C;
    localparam logic [7:0] DPC_OFS_ID = 8'h10;

    // Control register fields
    localparam int DPC_CTRL_SWING_BIT = 0;
    localparam int DPC_CTRL_LOWBAND_BIT = 1;
    localparam int DPC_CTRL_ORDER_BIT = 2;
    localparam int DPC_CTRL_OVR_LSB = 4;
    localparam int DPC_CTRL_SPREAD_ON_BIT = 8;
    localparam logic [2:0] DPC_CTRL_VAL_RST = 3'h0;
    localparam logic [2:0] DPC_CTRL_OVR_RST = 3'h0;
    localparam logic DPC_CTRL_SPREAD_ON_RST = 1'b0;

    // Status register fields
    localparam int DPC_ST_LOCK_BIT = 0;
    localparam int DPC_ST_TEST_BIT = 1;
    localparam int DPC_ST_PASS_BIT = 2;
    localparam int DPC_ST_BOOST_BIT = 3;
    localparam int DPC_ST_SPREAD_BIT = 4;
    localparam int DPC_ST_MODE_LSB = 8;

    // Interrupt bits, one per event
    localparam int DPC_EV_W = 4;
    localparam int DPC_EV_LOCK_GAINED = 0;
    localparam int DPC_EV_LOCK_LOST = 1;
    localparam int DPC_EV_TEST_ERROR = 2;
    localparam int DPC_EV_SPREAD_BLOCKED = 3;
    localparam logic [3:0] DPC_INT_STAT_RST = 4'h0;
    localparam logic [3:0] DPC_INT_MASK_RST = 4'h0;

    // Arbitrary identification value
    localparam logic [31:0] DPC_ID_VALUE = 32'h0000_D0C1;

    // Highest output clock rate at which spreading is offered
    localparam logic [7:0] DPC_SPREAD_MAX_MHZ = 8'd65;

    // Operating mode encodings
    localparam logic [1:0] DPC_MODE_NATIVE_RAW = 2'b00;
    localparam logic [1:0] DPC_MODE_NATIVE_FILT = 2'b01;
    localparam logic [1:0] DPC_MODE_LEGACY_A = 2'b10;
    localparam logic [1:0] DPC_MODE_LEGACY_B = 2'b11;

    typedef enum logic [1:0] {
        DPC_TST_IDLE = 2'b00,
        DPC_TST_PASS = 2'b01,
        DPC_TST_FAIL = 2'b10
    } dpc_test_e;
endpackage : dpc_pkg
`default_nettype wire

// [hdl/dpc_test_if.sv]
// Link between the configuration block and its self-test tracker
`timescale 1ns/100ps
`default_nettype none
interface dpc_test_if;
    logic request;
    logic error_pulse;
    logic active;
    logic pass;
    logic error_event;

    modport ctrl (output request, output error_pulse, input active, input pass, input error_event);
    modport tester (input request, input error_pulse, output active, output pass, output error_event);
endinterface : dpc_test_if
`default_nettype wire

// [hdl/dpc_self_test.sv]
// Self-test pass/fail tracker
`timescale 1ns/100ps
`default_nettype none
module dpc_self_test
    import dpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    dpc_test_if.tester tif
);
    typedef struct packed {
        dpc_test_e phase;
        logic active;
        logic pass;
        logic error_event;
    } dpc_tst_state_s;

    dpc_tst_state_s st_r;
    dpc_tst_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.error_event = 1'b0;
        case (st_r.phase)
            DPC_TST_IDLE: begin
                // Each new test run starts with a clean pass
                if (tif.request) begin
                    st_nxt.phase = DPC_TST_PASS;
                end
            end
            DPC_TST_PASS: begin
                if (!tif.request) begin
                    st_nxt.phase = DPC_TST_IDLE;
                end else if (tif.error_pulse) begin
                    st_nxt.phase = DPC_TST_FAIL;
                    st_nxt.error_event = 1'b1;
                end
            end
            DPC_TST_FAIL: begin
                // Failure sticks until the test is left
                if (!tif.request) begin
                    st_nxt.phase = DPC_TST_IDLE;
                end
            end
            default: begin
                st_nxt.phase = DPC_TST_IDLE;
            end
        endcase
        st_nxt.active = (st_nxt.phase != DPC_TST_IDLE);
        st_nxt.pass = (st_nxt.phase != DPC_TST_FAIL);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{phase: DPC_TST_IDLE, active: 1'b0, pass: 1'b1, error_event: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tif.active = st_r.active;
    assign tif.pass = st_r.pass;
    assign tif.error_event = st_r.error_event;
endmodule : dpc_self_test
`default_nettype wire

// [verification/dpc_deser_cfg_asserts.sv]
// Port-level checks for the deserializer configuration block
`timescale 1ns/100ps
`default_nettype none
module dpc_deser_cfg_asserts
    import dpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic power_down_bar,
    input wire logic output_drive_allow,
    input wire logic unlocked_output_state_choice,
    input wire logic [1:0] op_mode,
    input wire logic [2:0] spread_range_select,
    input wire logic self_test_request,
    input wire logic pass_pin_in,
    input wire logic pass_pin_out,
    input wire logic pass_pin_oe,
    input wire logic pll_locked,
    input wire logic bit_error,
    input wire logic [7:0] out_clk_mhz,
    input wire logic lock_out,
    input wire logic out_drive_en,
    input wire logic out_hold_state,
    input wire logic spread_en,
    input wire logic [2:0] spread_range,
    input wire logic native_mode,
    input wire logic filter_en,
    input wire logic legacy_mode_a,
    input wire logic legacy_mode_b,
    input wire logic input_boost_en,
    input wire logic self_test_active,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_locked;
        power_down_bar && pll_locked |=> lock_out && !out_hold_state && out_drive_en == $past(output_drive_allow);
    endproperty
    a_locked: assert property (p_locked) else $error("locked output state wrong");
    property p_unlocked;
        power_down_bar && !pll_locked |=> !lock_out && out_hold_state
            && out_drive_en == ($past(output_drive_allow) && $past(unlocked_output_state_choice));
    endproperty
    a_unlocked: assert property (p_unlocked) else $error("unlocked output state wrong");
    property p_pdown;
        !power_down_bar |=> !lock_out && !out_drive_en && !pass_pin_oe && !irq && !spread_en;
    endproperty
    a_pdown: assert property (p_pdown) else $error("outputs active in power down");
    property p_mode;
        power_down_bar |=> {native_mode, filter_en, legacy_mode_a, legacy_mode_b} == {$past(op_mode) < 2'h2,
            $past(op_mode) == DPC_MODE_NATIVE_FILT, $past(op_mode) == DPC_MODE_LEGACY_A,
            $past(op_mode) == DPC_MODE_LEGACY_B};
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode wrong");
    property p_range;
        power_down_bar |=> spread_range == $past(spread_range_select);
    endproperty
    a_range: assert property (p_range) else $error("spread range not followed");
    property p_spread;
        out_clk_mhz > DPC_SPREAD_MAX_MHZ |=> !spread_en;
    endproperty
    a_spread: assert property (p_spread) else $error("spreading above rate limit");
    property p_test;
        power_down_bar |=> self_test_active == $past(self_test_request);
    endproperty
    a_test: assert property (p_test) else $error("self-test entry wrong");
    property p_fail;
        power_down_bar && self_test_active && self_test_request && bit_error ##1 self_test_request && power_down_bar
            |=> !pass_pin_out;
    endproperty
    a_fail: assert property (p_fail) else $error("pass kept after error");
    property p_boost_take;
        $rose(pass_pin_oe) |-> input_boost_en == $past(pass_pin_in, 2);
    endproperty
    a_boost_take: assert property (p_boost_take) else $error("strap not captured");
    property p_boost_keep;
        pass_pin_oe && $past(pass_pin_oe) |-> $stable(input_boost_en);
    endproperty
    a_boost_keep: assert property (p_boost_keep) else $error("strap changed while pin driven");
    c_lock: cover property ($rose(lock_out));
    c_fail: cover property ($fell(pass_pin_out));
    c_irq: cover property ($rose(irq));
    c_spread: cover property ($fell(spread_en));
endmodule : dpc_deser_cfg_asserts
bind dpc_deser_cfg dpc_deser_cfg_asserts u_chk (.*);
`default_nettype wire

// [verification/dpc_link_model.sv]
// Behavioural far-end serializer: lock, bit errors, output clock rate
`timescale 1ns/100ps
`default_nettype none
module dpc_link_model #(
    parameter int LOCK_CYC = 4
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic link_up,
    input wire logic err_inject,
    input wire logic [7:0] rate,
    output logic pll_locked,
    output logic bit_error,
    output logic [7:0] out_clk_mhz
);
    int lock_cnt;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_cnt <= 0;
            pll_locked <= 1'b0;
            bit_error <= 1'b0;
        end else begin
            // Lock only after the link has run steadily for a while
            lock_cnt <= link_up ? ((lock_cnt < LOCK_CYC) ? lock_cnt + 1 : lock_cnt) : 0;
            pll_locked <= link_up && (lock_cnt >= LOCK_CYC);
            bit_error <= err_inject;
        end
    end
    assign out_clk_mhz = rate;
endmodule : dpc_link_model
`default_nettype wire

// [verification/dpc_deser_cfg_tb.sv]
// Self-checking bench for the deserializer configuration block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module dpc_deser_cfg_tb;
    import dpc_pkg::*;
    typedef struct packed {logic [1:0] mode; logic [2:0] rng; logic [2:0] pins; logic [3:0] dec;} dpc_tb_row_s;
    logic core_clk = 1'b0, arst_n = 1'b0, power_down_bar = 1'b1, output_drive_allow = 1'b0;
    logic unlocked_output_state_choice = 1'b0, lvds_swing_choice = 1'b0, low_band_choice = 1'b0;
    logic bit_order_choice = 1'b0, self_test_request = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic link_up = 1'b0, err_inject = 1'b0, strap = 1'b1;
    logic [1:0] op_mode = 2'h0;
    logic [2:0] spread_range_select = 3'h0;
    logic [7:0] reg_addr = 8'h00, rate = 8'h14;
    logic [31:0] reg_wdata = 32'h0;
    logic pass_pin_in, pass_pin_out, pass_pin_oe, pll_locked, bit_error, lock_out, out_drive_en, out_hold_state;
    logic lvds_swing_high, spread_low_band, spread_en, msb_on_lane_four, native_mode, filter_en;
    logic legacy_mode_a, legacy_mode_b, input_boost_en, self_test_active, irq;
    logic [2:0] spread_range;
    logic [7:0] out_clk_mhz;
    logic [31:0] reg_rdata;
    int n_fail = 0;
    int check_count = 0;
    int k;
    // Shared strap/pass wire; the strap level shows while the pin is released
    assign pass_pin_in = pass_pin_oe ? pass_pin_out : strap;
    dpc_deser_cfg dut (.*);
    dpc_link_model u_link (.*);
    dpc_tb_row_s rows [4] = '{'{2'h0, 3'h0, 3'h1, 4'h8}, '{2'h1, 3'h5, 3'h2, 4'hC},
                              '{2'h2, 3'h7, 3'h4, 4'h2}, '{2'h3, 3'h2, 3'h7, 4'h1}};
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task step();
        @(posedge core_clk);
        #1;
    endtask : step
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd
    task wait_lock(input logic v);
        k = 0;
        while (lock_out !== v && k < 20) begin
            step();
            k++;
        end
        `CHK("lock_out", v, lock_out)
    endtask : wait_lock
    task finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) step();
        `CHK("input_boost_en", 1'b1, input_boost_en)
        `CHK("pass_pin_oe", 1'b1, pass_pin_oe)
        rd(DPC_OFS_CTRL, 32'h0);
        rd(DPC_OFS_INT_MASK, 32'h0);
        rd(8'h20, 32'h0);
        rd(DPC_OFS_ID, DPC_ID_VALUE);
        foreach (rows[i]) begin
            @(posedge core_clk);
            op_mode <= rows[i].mode;
            spread_range_select <= rows[i].rng;
            {bit_order_choice, low_band_choice, lvds_swing_choice} <= rows[i].pins;
            step();
            `CHK("decode", rows[i].dec, {native_mode, filter_en, legacy_mode_a, legacy_mode_b})
            `CHK("range", rows[i].rng, spread_range)
            `CHK("pins", rows[i].pins, {msb_on_lane_four, spread_low_band, lvds_swing_high})
        end
        wr(DPC_OFS_INT_MASK, 32'h3);
        @(posedge core_clk);
        output_drive_allow <= 1'b1;
        unlocked_output_state_choice <= 1'b1;
        link_up <= 1'b1;
        wait_lock(1'b1);
        `CHK("drive_en", 1'b1, out_drive_en)
        `CHK("irq", 1'b1, irq)
        @(posedge core_clk);
        output_drive_allow <= 1'b0;
        step();
        `CHK("drive_en", 1'b0, out_drive_en)
        rd(DPC_OFS_INT_STAT, 32'h1);
        `CHK("irq", 1'b0, irq)
        @(posedge core_clk);
        link_up <= 1'b0;
        output_drive_allow <= 1'b1;
        unlocked_output_state_choice <= 1'b0;
        wait_lock(1'b0);
        `CHK("drive_en", 1'b0, out_drive_en)
        `CHK("hold", 1'b1, out_hold_state)
        @(posedge core_clk);
        unlocked_output_state_choice <= 1'b1;
        step();
        `CHK("drive_en", 1'b1, out_drive_en)
        rd(DPC_OFS_INT_STAT, 32'h2);
        @(posedge core_clk);
        lvds_swing_choice <= 1'b0;
        rate <= 8'd65;
        wr(DPC_OFS_CTRL, 32'h111);
        step();
        `CHK("swing", 1'b1, lvds_swing_high)
        `CHK("spread_en", 1'b1, spread_en)
        @(posedge core_clk);
        rate <= 8'd66;
        step();
        `CHK("spread_en", 1'b0, spread_en)
        rd(DPC_OFS_INT_STAT, 32'h8);
        @(posedge core_clk);
        self_test_request <= 1'b1;
        step();
        `CHK("test_active", 1'b1, self_test_active)
        step();
        `CHK("pass", 1'b1, pass_pin_out)
        @(posedge core_clk);
        err_inject <= 1'b1;
        @(posedge core_clk);
        err_inject <= 1'b0;
        k = 0;
        while (pass_pin_out !== 1'b0 && k < 10) begin
            step();
            k++;
        end
        `CHK("pass", 1'b0, pass_pin_out)
        rd(DPC_OFS_STATUS, 32'h0000_030A);
        rd(DPC_OFS_INT_STAT, 32'h4);
        @(posedge core_clk);
        self_test_request <= 1'b0;
        step();
        `CHK("test_active", 1'b0, self_test_active)
        step();
        `CHK("pass", 1'b1, pass_pin_out)
        @(posedge core_clk);
        strap <= 1'b0;
        power_down_bar <= 1'b0;
        step();
        `CHK("pass_oe", 1'b0, pass_pin_oe)
        `CHK("swing", 1'b0, lvds_swing_high)
        wr(DPC_OFS_CTRL, 32'h111);
        rd(DPC_OFS_CTRL, 32'h0);
        `CHK("input_boost_en", 1'b1, input_boost_en)
        @(posedge core_clk);
        power_down_bar <= 1'b1;
        step();
        step();
        `CHK("input_boost_en", 1'b0, input_boost_en)
        `CHK("pass_oe", 1'b1, pass_pin_oe)
        finish_test();
    end
endmodule : dpc_deser_cfg_tb
`default_nettype wire
